// [dv/usbrd_i2c_m.sv]
// Serial bus master model for the register port
`timescale 1ns/10ps
module usbrd_i2c_m (
   input  wire logic i_clock,  // Core clock
   input  wire logic i_sda_oe, // Device pulls data low
   output logic      o_scl,    // Serial clock level
   output logic      o_sda     // Data wire, pulled up
);
   logic pull_q = 1'b0; // Master pulls data low
   assign o_sda = ~(pull_q | i_sda_oe); // Open drain, pull-up wins idle
   initial o_scl = 1'b1;
   // Clock stands high between frames; start if a is 1, stop if 0
   task automatic frame(input logic a);
      o_scl = 1'b0;
      @(negedge i_clock) pull_q = ~a;
      repeat (4) @(negedge i_clock);
      o_scl = 1'b1;
      repeat (4) @(negedge i_clock);
      pull_q = a;
      repeat (4) @(negedge i_clock);
   endtask
   // One bit in 400 ns; data moves only while clock is low
   task automatic bit_io(input logic b, output logic r);
      o_scl = 1'b0;
      @(negedge i_clock) pull_q = ~b;
      repeat (4) @(negedge i_clock);
      o_scl = 1'b1;
      @(negedge i_clock) r = o_sda;
      repeat (2) @(negedge i_clock);
   endtask
   // Eight bits first msb, then the acknowledge bit
   task automatic xfer(input logic [7:0] w, input logic ak,
                       output logic [7:0] r, output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(ak, nak);
   endtask
endmodule

// [dv/usbrd_top_chk.sv]
// Assertion checker bound to the redriver control block
`timescale 1ns/10ps
module usbrd_top_chk (
   input wire logic       i_clock,           // Core clock
   input wire logic       i_arst_n,          // Shutdown, low
   input wire logic [1:0] i_line_speed,      // Detected speed
   input wire logic       i_fixture,         // Fixture seen
   input wire logic       o_scl_oe,          // Clock pin enable
   input wire logic       o_sda_oe,          // Data pull low
   input wire logic       o_sda_out,         // Data drive value
   input wire logic       o_connection_flag, // Connection flag
   input wire logic       o_hs_active_flag,  // HS active flag
   input usbrd_pkg::usbrd_comp_t o_comp      // Compensation
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   // Both flags low, as in shutdown
   sequence quiet_s; !o_connection_flag && !o_hs_active_flag; endsequence
   a_comp_hs_tie: assert property (o_comp.enable == o_hs_active_flag)
      else $error("compensation and HS flag disagree");
   a_sda_low_only: assert property (o_sda_out == 1'b0)
      else $error("data pin driven high");
   a_scl_mode_kept: assert property (o_scl_oe |=> o_scl_oe)
      else $error("flag output on clock pin dropped");
   a_no_ack_off: assert property (o_scl_oe |-> !o_sda_oe)
      else $error("serial answer while port disabled");
   a_wake_quiet: assert property ($rose(i_arst_n) |-> quiet_s [*2])
      else $error("flags not low on wake");
   a_ack_hold: assert property ($rose(o_sda_oe) |=> o_sda_oe [*3])
      else $error("data pull too short");
   a_hs_cause: assert property ($rose(o_hs_active_flag) |->
      i_line_speed == usbrd_pkg::USBRD_SPD_HS || i_fixture)
      else $error("HS flag without cause");
   a_cd_cause: assert property ($rose(o_connection_flag) |->
      i_line_speed != usbrd_pkg::USBRD_SPD_NONE)
      else $error("connection flag without link");
endmodule
bind usbrd_top usbrd_top_chk u_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
   .i_line_speed(i_line_speed), .i_fixture(i_fixture), .o_scl_oe(o_scl_oe),
   .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out), .o_comp(o_comp),
   .o_connection_flag(o_connection_flag), .o_hs_active_flag(o_hs_active_flag));

// [dv/usbrd_top_tb.sv]
// Self-checking bench of the redriver control block
`timescale 1ns/10ps
module usbrd_top_tb;
   logic       i_clock = 1'b0;  // Core clock, 50 ns
   logic       i_arst_n = 1'b0; // Shutdown pin
   logic [1:0] gain = 2'h2;     // Gain strap level
   logic [1:0] rxs = 2'h1;      // Sensitivity strap, middle
   logic [1:0] spd = 2'h0;      // Link speed
   logic       fix = 1'b0;      // Fixture present
   logic       ce = 1'b1;       // Clock enable
   logic       scl, scl_w, sda, sda_oe, sda_out, sc_out, sc_oe, cd, hs;
   usbrd_pkg::usbrd_comp_t comp; // Compensation seen
   int err_total = 0;
   int compares = 0;
   always #25 i_clock = ~i_clock;
   assign scl_w = sc_oe ? sc_out : scl; // Device owns pin without serial port
   usbrd_i2c_m M (.i_clock(i_clock), .i_sda_oe(sda_oe), .o_scl(scl),
                  .o_sda(sda));
   usbrd_top DUT (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_ce(ce),
      .i_gain_strap(gain), .i_rx_sens_strap(rxs), .i_line_speed(spd),
      .i_fixture(fix), .i_scl(scl_w), .i_sda(sda), .o_scl_out(sc_out),
      .o_scl_oe(sc_oe), .o_sda_oe(sda_oe), .o_sda_out(sda_out),
      .o_connection_flag(cd), .o_hs_active_flag(hs), .o_comp(comp));
   task automatic check(input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %0t seen %h want %h", $time, s, e);
      end
   endtask
   // Offset write, then a data write or repeated start and one read
   task automatic acc(input logic [7:0] a, d, input logic rd);
      logic [7:0] r;
      logic n;
      M.frame(1'b1);
      M.xfer({usbrd_pkg::SLAVE_ADDR, 1'b0}, 1'b1, r, n);
      check(n, 1'b0);
      M.xfer(a, 1'b1, r, n);
      if (rd) begin
         M.frame(1'b1);
         M.xfer({usbrd_pkg::SLAVE_ADDR, 1'b1}, 1'b1, r, n);
         M.xfer(8'hff, 1'b1, r, n);
         check(r, d);
      end else
         M.xfer(d, 1'b1, r, n);
      M.frame(1'b0);
   endtask
   // Set link state, let it settle, judge flags and compensation
   task automatic mode(input logic [1:0] s, input logic f, input logic [1:0] x);
      spd = s;
      fix = f;
      repeat (10) @(negedge i_clock);
      check({cd, hs, comp.enable}, {x, x[0]});
   endtask
   // Shutdown pulse; wait past the strap sample point after wake
   task automatic pulse();
      i_arst_n = 1'b0;
      repeat (2000) @(negedge i_clock);
      check({cd, hs, comp.enable}, 3'h0);
      i_arst_n = 1'b1;
      repeat (260) @(negedge i_clock);
   endtask
   // Data held low at wake: clock pin carries the connection flag
   task automatic noport();
      spd = 2'h2;
      fix = 1'b0;
      M.pull_q = 1'b1;
      pulse();
      M.pull_q = 1'b0;
      mode(2'h2, 1'b0, 2'h2);
      check({sc_oe, sc_out, sda_out}, 3'h6);
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      logic [7:0] r;
      logic n;
      repeat (3) @(negedge i_clock);
      i_arst_n = 1'b1;
      repeat (260) @(negedge i_clock);
      acc(usbrd_pkg::REG_EDGE_GAIN, 8'h60, 1'b1);
      acc(usbrd_pkg::REG_STATIC, 8'h02, 1'b1);
      acc(usbrd_pkg::REG_RX_SENS, 8'h44, 1'b1);
      acc(usbrd_pkg::REG_SETUP, 8'h01, 1'b1);
      acc(8'h02, 8'h00, 1'b1);
      mode(2'h1, 1'b0, 2'h0);
      acc(usbrd_pkg::REG_SETUP, 8'h00, 1'b0);
      mode(2'h1, 1'b0, 2'h2);
      mode(2'h2, 1'b0, 2'h2);
      mode(2'h3, 1'b0, 2'h3);
      check(comp[15:0], 16'h6244);
      ce = 1'b0;
      mode(2'h0, 1'b1, 2'h3);
      spd = 2'h3;
      fix = 1'b0;
      ce = 1'b1;
      gain = 2'h3;
      rxs = 2'h2;
      acc(usbrd_pkg::REG_EDGE_GAIN, 8'hf0, 1'b0);
      acc(usbrd_pkg::REG_EDGE_GAIN, 8'hf0, 1'b1);
      pulse();
      acc(usbrd_pkg::REG_SETUP, 8'h00, 1'b0);
      mode(2'h3, 1'b0, 2'h1);
      acc(usbrd_pkg::REG_EDGE_GAIN, 8'h80, 1'b1);
      acc(usbrd_pkg::REG_STATIC, 8'h06, 1'b1);
      acc(usbrd_pkg::REG_RX_SENS, 8'h77, 1'b1);
      mode(2'h0, 1'b0, 2'h0);
      mode(2'h0, 1'b1, 2'h1);
      M.frame(1'b1);
      M.xfer({7'h2d, 1'b0}, 1'b1, r, n);
      check(n, 1'b1);
      M.frame(1'b0);
      noport();
      report_and_stop();
   end
   initial begin
      #2_000_000;
      err_total++;
      report_and_stop();
   end
endmodule

// [logic/usbrd_pkg.sv]
// Package of constants and types for the redriver control block
package usbrd_pkg;
   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] REG_EDGE_GAIN  = 8'h01; // Edge gain level
   localparam logic [7:0] REG_SETUP      = 8'h03; // Device setup control
   localparam logic [7:0] REG_STATIC     = 8'h0e; // Static gain level
   localparam logic [7:0] REG_RX_SENS    = 8'h25; // Receive sensitivity
   localparam int         REG_IDX_W      = 2;     // Register store index
   localparam logic [1:0] IDX_EDGE       = 2'h0;  // Store slot, edge gain
   localparam logic [1:0] IDX_SETUP      = 2'h1;  // Store slot, setup
   localparam logic [1:0] IDX_STATIC     = 2'h2;  // Store slot, static
   localparam logic [1:0] IDX_RX         = 2'h3;  // Store slot, rx sens
   localparam logic [7:0] UNMAPPED_READ  = 8'h00; // Reserved offsets read
   // ***************************************************************
   // Serial port
   // ***************************************************************
   localparam logic [6:0] SLAVE_ADDR     = 7'h2c; // Own serial address
   localparam logic [2:0] BIT_LAST       = 3'h7;  // Last bit of a byte
   // ***************************************************************
   // Field values loaded from straps
   // ***************************************************************
   localparam logic [3:0] EDGE_LVL0      = 4'h0;  // Edge gain, level 0
   localparam logic [3:0] EDGE_LVL1      = 4'h3;  // Edge gain, level 1
   localparam logic [3:0] EDGE_LVL2      = 4'h6;  // Edge gain, level 2
   localparam logic [3:0] EDGE_LVL3      = 4'h8;  // Edge gain, level 3
   localparam logic [3:0] STAT_LVL0      = 4'h0;  // Static gain, level 0
   localparam logic [3:0] STAT_LVL12     = 4'h2;  // Static gain, 1 and 2
   localparam logic [3:0] STAT_LVL3      = 4'h6;  // Static gain, level 3
   localparam logic [7:0] RX_LOW         = 8'h00; // Rx sens, strap low
   localparam logic [7:0] RX_MID         = 8'h44; // Rx sens, strap middle
   localparam logic [7:0] RX_HIGH        = 8'h77; // Rx sens, strap high
   localparam logic [3:0] RSVD_NIBBLE    = 4'h0;  // Reserved bits at reset
   localparam logic [6:0] RSVD_SETUP     = 7'h00; // Setup reserved bits
   localparam logic       HOLD_RESET     = 1'b1;  // Hold bit after reset
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_HZ       = 20_000_000;  // Core clock rate
   localparam int SAMPLE_US    = 10;          // Strap sample delay
   localparam int SAMPLE_CYC   = (SAMPLE_US * (CLK_HZ / 1_000_000));
   localparam int SAMPLE_W     = 9;           // Width of sample counter
   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      USBRD_STRAP_LOW  = 2'h0,
      USBRD_STRAP_MID  = 2'h1,
      USBRD_STRAP_HIGH = 2'h2
   } usbrd_tri_t;
   // Gray coded along the usual path from off to high speed
   typedef enum logic [2:0] {
      USBRD_ST_SHUT  = 3'b000,
      USBRD_ST_IDLE  = 3'b001,
      USBRD_ST_SLOW  = 3'b011,
      USBRD_ST_HS    = 3'b010,
      USBRD_ST_EYE   = 3'b110
   } usbrd_state_t;
   typedef enum logic [1:0] {
      USBRD_SPD_NONE = 2'h0,
      USBRD_SPD_LS   = 2'h1,
      USBRD_SPD_FS   = 2'h2,
      USBRD_SPD_HS   = 2'h3
   } usbrd_speed_t;
   // Settings handed to the analog compensation path
   typedef struct packed {
      logic       enable;
      logic [3:0] edge_gain;
      logic [3:0] static_gain;
      logic [7:0] rx_sens;
   } usbrd_comp_t;
   // Register store write request
   typedef struct packed {
      logic       we;
      logic [1:0] idx;
      logic [7:0] data;
   } usbrd_wr_t;
endpackage

// [logic/usbrd_regmem.sv]
// Little register store for the four configuration registers
`timescale 1ns/10ps
module usbrd_regmem #(
   parameter int DEPTH = 4,                       // Number of registers
   parameter int AW    = 2                        // Index width
) (
   input  wire logic             i_clock,         // Core clock
   input  wire logic             i_arst_n,        // Async reset, low
   input  wire logic             i_ce,            // Clock enable
   input  wire logic             i_load,          // Strap load strobe
   input  wire logic [DEPTH*8-1:0] i_load_data,   // Strap values, all regs
   input  usbrd_pkg::usbrd_wr_t  i_wr,            // Serial port write
   input  wire logic [AW-1:0]    i_rd_idx,        // Read index
   output logic [7:0]            o_rd_data,       // Registered read data
   output logic [DEPTH*8-1:0]    o_all            // Live contents
);
   logic [7:0] mem_q [DEPTH];                     // Storage
   logic [7:0] mem_d [DEPTH];                     // Next storage
   logic [7:0] rd_q;                              // Read register
   logic [7:0] rd_d;                              // Next read data

   // Next values: strap load takes priority over a serial write
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
         if (i_load) begin
            mem_d[i] = i_load_data[i*8 +: 8];
         end else if (i_wr.we && (i_wr.idx == AW'(i))) begin
            mem_d[i] = i_wr.data;
         end
      end
      rd_d = mem_q[i_rd_idx];
   end

   // Registers
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
         rd_q <= 8'h00;
      end else if (i_ce) begin
         mem_q <= mem_d;
         rd_q  <= rd_d;
      end
   end

   assign o_rd_data = rd_q;
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         o_all[i*8 +: 8] = mem_q[i];
      end
   end
endmodule

// [logic/usbrd_sync.sv]
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module usbrd_sync #(
   parameter int W = 1                            // Bundle width
) (
   input  wire logic         i_clock,             // Core clock
   input  wire logic         i_arst_n,            // Async reset, low
   input  wire logic         i_ce,                // Clock enable
   input  wire logic [W-1:0] i_async,             // Raw pin levels
   output logic [W-1:0]      o_sync               // Synchronised levels
);
   logic [W-1:0] meta_q;                          // First stage only
   logic [W-1:0] sync_q;                          // Second stage

   // Two stages; only the second stage is read outside
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (i_ce) begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule

// [logic/usbrd_top.sv]
// Control block of the high speed signal conditioner
`timescale 1ns/10ps
module usbrd_top (
   input  wire logic       i_clock,        // Core clock, 20 MHz
   input  wire logic       i_arst_n,       // Shutdown pin, active low
   input  wire logic       i_ce,           // Clock enable
   input  wire logic [1:0] i_gain_strap,   // Decoded gain strap level
   input  wire logic [1:0] i_rx_sens_strap,// Tri-level strap code
   input  wire logic [1:0] i_line_speed,   // Detected link speed
   input  wire logic       i_fixture,      // Compliance fixture seen
   input  wire logic       i_scl,          // Serial clock pin level
   input  wire logic       i_sda,          // Serial data pin level
   output logic            o_scl_out,      // Serial clock pin drive
   output logic            o_scl_oe,       // Serial clock pin enable
   output logic            o_sda_oe,       // Serial data pull low
   output logic            o_sda_out,      // Serial data drive value
   output logic            o_connection_flag, // Connection flag
   output logic            o_hs_active_flag,  // High speed active flag
   output usbrd_pkg::usbrd_comp_t o_comp   // Compensation settings
);
   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [8:0] pins_s;                     // Synchronised pin levels
   usbrd_sync #(.W(9)) u_sync (
      .i_clock (i_clock),
      .i_arst_n(i_arst_n),
      .i_ce    (i_ce),
      .i_async ({i_gain_strap, i_rx_sens_strap, i_line_speed,
                 i_fixture, i_scl, i_sda}),
      .o_sync  (pins_s)
   );
   logic [1:0] gain_s;                     // Gain strap level
   logic [1:0] rxs_s;                      // Sensitivity strap code
   logic [1:0] spd_s;                      // Link speed
   logic       fix_s;                      // Fixture detect
   logic       scl_s;                      // Serial clock
   logic       sda_s;                      // Serial data
   assign {gain_s, rxs_s, spd_s, fix_s, scl_s, sda_s} = pins_s;

   // ***************************************************************
   // Strap decode
   // ***************************************************************
   function automatic logic [7:0] edge_of(input logic [1:0] lvl);
      case (lvl)
         2'h0:    edge_of = {usbrd_pkg::EDGE_LVL0, usbrd_pkg::RSVD_NIBBLE};
         2'h1:    edge_of = {usbrd_pkg::EDGE_LVL1, usbrd_pkg::RSVD_NIBBLE};
         2'h2:    edge_of = {usbrd_pkg::EDGE_LVL2, usbrd_pkg::RSVD_NIBBLE};
         default: edge_of = {usbrd_pkg::EDGE_LVL3, usbrd_pkg::RSVD_NIBBLE};
      endcase
   endfunction
   function automatic logic [7:0] static_of(input logic [1:0] lvl);
      case (lvl)
         2'h0:    static_of = {usbrd_pkg::RSVD_NIBBLE, usbrd_pkg::STAT_LVL0};
         2'h3:    static_of = {usbrd_pkg::RSVD_NIBBLE, usbrd_pkg::STAT_LVL3};
         default: static_of = {usbrd_pkg::RSVD_NIBBLE, usbrd_pkg::STAT_LVL12};
      endcase
   endfunction
   function automatic logic [7:0] rx_of(input logic [1:0] code);
      case (code)
         usbrd_pkg::USBRD_STRAP_LOW:  rx_of = usbrd_pkg::RX_LOW;
         usbrd_pkg::USBRD_STRAP_HIGH: rx_of = usbrd_pkg::RX_HIGH;
         default:                     rx_of = usbrd_pkg::RX_MID;
      endcase
   endfunction
   // Offset to store slot; valid flag in bit 2
   function automatic logic [2:0] slot_of(input logic [7:0] off);
      if (off == usbrd_pkg::REG_EDGE_GAIN) slot_of = {1'b1, usbrd_pkg::IDX_EDGE};
      else if (off == usbrd_pkg::REG_SETUP) slot_of = {1'b1, usbrd_pkg::IDX_SETUP};
      else if (off == usbrd_pkg::REG_STATIC) slot_of = {1'b1, usbrd_pkg::IDX_STATIC};
      else if (off == usbrd_pkg::REG_RX_SENS) slot_of = {1'b1, usbrd_pkg::IDX_RX};
      else slot_of = 3'h0;
   endfunction

   // ***************************************************************
   // Wake sequence: strap sample after reset release
   // ***************************************************************
   // Straps are only caught here, a delay after release, so later pin
   // changes are ignored until the next shutdown toggle.
   logic [usbrd_pkg::SAMPLE_W-1:0] wait_q, wait_d; // Sample delay count
   logic       woke_q, woke_d;             // Straps sampled
   logic       i2c_en_q, i2c_en_d;         // Serial port enabled
   logic       load;                       // One-cycle load strobe
   always_comb begin
      wait_d   = wait_q;
      woke_d   = woke_q;
      i2c_en_d = i2c_en_q;
      load     = 1'b0;
      if (!woke_q) begin
         if (wait_q == usbrd_pkg::SAMPLE_W'(usbrd_pkg::SAMPLE_CYC)) begin
            load     = 1'b1;
            woke_d   = 1'b1;
            i2c_en_d = scl_s && sda_s;
         end else begin
            wait_d = wait_q + 1'b1;
         end
      end
   end
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wait_q   <= '0;
         woke_q   <= 1'b0;
         i2c_en_q <= 1'b0;
      end else if (i_ce) begin
         wait_q   <= wait_d;
         woke_q   <= woke_d;
         i2c_en_q <= i2c_en_d;
      end
   end

   // ***************************************************************
   // Register store
   // ***************************************************************
   usbrd_pkg::usbrd_wr_t wr;               // Serial write request
   logic [1:0]  rd_idx;                    // Read slot
   logic [7:0]  rd_data;                   // Read data
   logic [31:0] regs;                      // All register contents
   logic [31:0] strap_vals;                // Values loaded at wake
   assign strap_vals = {rx_of(rxs_s),
                        static_of(gain_s),
                        {usbrd_pkg::RSVD_SETUP, usbrd_pkg::HOLD_RESET},
                        edge_of(gain_s)};
   usbrd_regmem u_mem (
      .i_clock    (i_clock),
      .i_arst_n   (i_arst_n),
      .i_ce       (i_ce),
      .i_load     (load),
      .i_load_data(strap_vals),
      .i_wr       (wr),
      .i_rd_idx   (rd_idx),
      .o_rd_data  (rd_data),
      .o_all      (regs)
   );
   logic hold;                             // Mode machine halted
   // Without the serial port nobody can clear hold, so it only applies
   // when the port is enabled
   assign hold = i2c_en_q && regs[8];

   // ***************************************************************
   // Serial slave
   // ***************************************************************
   logic scl_d1_q, sda_d1_q;               // Previous line levels
   logic [2:0] bit_q, bit_d;               // Bit count in byte
   logic [7:0] sh_q, sh_d;                 // Shift register
   logic [1:0] ph_q, ph_d;                 // 0 addr,1 offset,2 data,3 idle
   logic       rd_q, rd_d;                 // Read transfer
   logic       ack_q, ack_d;               // In acknowledge bit
   logic [7:0] off_q, off_d;               // Register offset
   logic       sda_oe_q, sda_oe_d;         // Pull data low
   usbrd_pkg::usbrd_wr_t wr_d;
   logic scl_rise, scl_fall, start, stop;
   logic [2:0] slot;                       // Offset slot, valid in bit 2
   assign scl_rise = scl_s && !scl_d1_q;
   assign scl_fall = !scl_s && scl_d1_q;
   assign start    = scl_s && scl_d1_q && sda_d1_q && !sda_s;
   assign stop     = scl_s && scl_d1_q && !sda_d1_q && sda_s;
   assign slot     = slot_of(off_q);
   assign rd_idx   = slot[1:0];

   // Byte engine: address, then offset and one data byte in, or one data byte out
   always_comb begin
      bit_d = bit_q; sh_d = sh_q; ph_d = ph_q; rd_d = rd_q;
      ack_d = ack_q; off_d = off_q; sda_oe_d = sda_oe_q;
      wr_d  = '0;
      if (!i2c_en_q || stop) begin
         ph_d = 2'h3; sda_oe_d = 1'b0; ack_d = 1'b0;
      end else if (start) begin
         // The fall after a start closes no bit; treat it like the end
         // of an acknowledge so the first byte counts eight bits
         ph_d = 2'h0; bit_d = '0; ack_d = 1'b1; sda_oe_d = 1'b0;
      end else if (scl_rise && !ack_q && ph_q != 2'h3 &&
                   !(ph_q == 2'h2 && rd_q)) begin
         // Only incoming bits shift here; read data shifts on falls
         sh_d = {sh_q[6:0], sda_s};
      end else if (scl_fall && (ph_q != 2'h3 || ack_q)) begin
         // An ack after the last byte must still be released
         if (ack_q) begin
            ack_d = 1'b0; sda_oe_d = 1'b0; bit_d = '0;
            if (ph_q == 2'h2 && rd_q) begin
               sh_d = slot[2] ? rd_data
                                          : usbrd_pkg::UNMAPPED_READ;
               sda_oe_d = !sh_d[7];
            end
         end else if (ph_q == 2'h2 && rd_q) begin
            bit_d = bit_q + 1'b1;
            sh_d  = {sh_q[6:0], 1'b1};
            sda_oe_d = (bit_q == usbrd_pkg::BIT_LAST) ? 1'b0 : !sh_q[6];
            if (bit_q == usbrd_pkg::BIT_LAST) ph_d = 2'h3;
         end else if (bit_q == usbrd_pkg::BIT_LAST) begin
            ack_d = 1'b1; sda_oe_d = 1'b1;
            case (ph_q)
               2'h0: begin
                  if (sh_q[7:1] == usbrd_pkg::SLAVE_ADDR) begin
                     rd_d = sh_q[0]; ph_d = sh_q[0] ? 2'h2 : 2'h1;
                  end else begin
                     ph_d = 2'h3; ack_d = 1'b0; sda_oe_d = 1'b0;
                  end
               end
               2'h1: begin
                  off_d = sh_q; ph_d = 2'h2;
               end
               default: begin
                  if (slot[2]) begin
                     wr_d = '{we: 1'b1, idx: slot[1:0],
                              data: sh_q};
                  end
                  ph_d = 2'h3;
               end
            endcase
         end else begin
            bit_d = bit_q + 1'b1;
         end
      end
   end
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         scl_d1_q <= 1'b1; sda_d1_q <= 1'b1; bit_q <= '0; sh_q <= '0;
         ph_q <= 2'h3; rd_q <= 1'b0; ack_q <= 1'b0; off_q <= '0;
         sda_oe_q <= 1'b0; wr <= '0;
      end else if (i_ce) begin
         scl_d1_q <= scl_s; sda_d1_q <= sda_s; bit_q <= bit_d;
         sh_q <= sh_d; ph_q <= ph_d; rd_q <= rd_d; ack_q <= ack_d;
         off_q <= off_d; sda_oe_q <= sda_oe_d; wr <= wr_d;
      end
   end

   // ***************************************************************
   // Mode machine
   // ***************************************************************
   usbrd_pkg::usbrd_state_t st_q, st_d;    // Mode state
   always_comb begin
      st_d = st_q;
      case (st_q)
         usbrd_pkg::USBRD_ST_SHUT: begin
            // Shutdown pulse during HS leaves us in eye test
            if (woke_q) st_d = usbrd_pkg::USBRD_ST_IDLE;
         end
         usbrd_pkg::USBRD_ST_EYE: begin
            if (spd_s == usbrd_pkg::USBRD_SPD_NONE && !fix_s)
               st_d = usbrd_pkg::USBRD_ST_IDLE;
         end
         default: begin
            if (fix_s) st_d = usbrd_pkg::USBRD_ST_EYE;
            else if (spd_s == usbrd_pkg::USBRD_SPD_HS)
               st_d = usbrd_pkg::USBRD_ST_HS;
            else if (spd_s == usbrd_pkg::USBRD_SPD_NONE)
               st_d = usbrd_pkg::USBRD_ST_IDLE;
            else st_d = usbrd_pkg::USBRD_ST_SLOW;
         end
      endcase
      if (hold) st_d = st_q;
   end
   // The HS flag survives reset so a shutdown pulse can be told apart
   logic was_hs_q, was_hs_d;               // Was in HS before shutdown
   assign was_hs_d = (st_q == usbrd_pkg::USBRD_ST_HS);
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q <= usbrd_pkg::USBRD_ST_SHUT;
      end else if (i_ce) begin
         if (st_q == usbrd_pkg::USBRD_ST_SHUT && woke_q && was_hs_q)
            st_q <= usbrd_pkg::USBRD_ST_EYE;
         else st_q <= st_d;
      end
   end
   // Deliberately not reset by the shutdown pin
   always_ff @(posedge i_clock) begin
      if (i_ce && st_q != usbrd_pkg::USBRD_ST_SHUT) was_hs_q <= was_hs_d;
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   logic cd_d, hs_d;
   usbrd_pkg::usbrd_comp_t comp_d;
   always_comb begin
      cd_d = (st_q == usbrd_pkg::USBRD_ST_SLOW) ||
             (st_q == usbrd_pkg::USBRD_ST_HS);
      hs_d = (st_q == usbrd_pkg::USBRD_ST_HS) ||
             (st_q == usbrd_pkg::USBRD_ST_EYE);
      comp_d.enable      = hs_d;
      comp_d.edge_gain   = regs[7:4];
      comp_d.static_gain = regs[19:16];
      comp_d.rx_sens     = regs[31:24];
   end
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_connection_flag <= 1'b0;
         o_hs_active_flag  <= 1'b0;
         o_comp            <= '0;
         o_scl_out         <= 1'b0;
         o_scl_oe          <= 1'b0;
         o_sda_oe          <= 1'b0;
         o_sda_out         <= 1'b0;
      end else if (i_ce) begin
         o_connection_flag <= cd_d;
         o_hs_active_flag  <= hs_d;
         o_comp            <= comp_d;
         o_scl_out         <= cd_d;
         o_scl_oe          <= woke_q && !i2c_en_q;
         o_sda_oe          <= sda_oe_q;
         o_sda_out         <= 1'b0;
      end
   end
endmodule
